// ---- verilog/pio_port.sv ----
// Parallel I/O port: latent reads, strobed writes, passive access,
// status/control split and input register shadowing.
// Assumes a classic Wishbone master on clk_i and asynchronous strobe pins.
//
// The address map and register access over Wishbone were decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "pio_regs.svh"

// Functional notes
// - Program reads return input register contents
// - Active read launches transfer, loads input register
// - One input register shared by both ports
// - Output writes never touch input register
// - Port select high for port one
// - Active read drives input strobe low
// - Input register captured on input strobe rise
// - Active write drives strobe low, data valid
// - Passive reader strobe low drives output register
// - Strobe width code gives T to 4T
// - Minimum width allows back-to-back transactions
// - Software spaces port accesses for wider strobes
// - Control bit 12 clear: output strobe input
// - Control bit 11 clear: input strobe input
// - Bit 10 makes upper byte input-only
// - Status/control output only on low byte
// - Passive write strobe rise raises masked request
// - Passive read strobe rise raises masked request
// - Acknowledge rises on entry, falls on exit
// - Active input strobe shadows register on interrupts
// - Switching to passive inside routine skips restore
// - Reset clears control except bit 3
// - Program read clears passive write flag
// - Program write clears passive read flag
module pio_port (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [3:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // Parallel data bus
    input wire logic [15:0] parallel_data_bus_i,
    output logic [15:0] parallel_data_bus_o,
    output logic [15:0] parallel_data_bus_oe_o,
    // Strobes, three signals each
    input wire logic input_data_strobe_n_i,
    output logic input_data_strobe_n_o,
    output logic input_data_strobe_n_oe_o,
    input wire logic output_data_strobe_n_i,
    output logic output_data_strobe_n_o,
    output logic output_data_strobe_n_oe_o,
    // Port select and interrupt
    output logic port_select_o,
    output logic interrupt_acknowledge_o,
    output logic irq_o
);
    pio_pkg::pio_state_t state_q;
    pio_pkg::pio_bus_t bus_q;
    logic [15:0] ctrl_q;
    logic [15:0] in_q;
    logic [15:0] out_q;
    logic [15:0] shadow_q;
    logic shadow_vld_q;
    logic sel_q;
    logic interrupt_acknowledge_q;
    logic ack_q;
    logic [31:0] rdat_q;
    logic [4:0] cnt_q;
    logic ids_on_q;
    logic ods_on_q;
    logic [2:0] ids_sync_q;
    logic [2:0] ods_sync_q;
    logic ids_lvl_q;
    logic ods_lvl_q;
    logic [15:0] pdb_s1_q;
    logic [15:0] pdb_s2_q;
    logic [15:0] pdb_s3_q;
    logic [15:0] pdb_hold_q;

    // Strobe length in clocks: (code + 1) * T
    function automatic logic [4:0] strobe_cycles(input logic [1:0] code);
        strobe_cycles = 5'({2'b00, code} + 4'h1) * 5'(`PIO_T_CYCLES);
    endfunction : strobe_cycles

    function automatic logic port_hit(input logic [3:0] adr);
        port_hit = (adr == `PIO_ADR_PORT0) || (adr == `PIO_ADR_PORT1);
    endfunction : port_hit

    logic req;
    logic wr_ok;
    logic rd_ok;
    logic ids_act;
    logic ods_act;
    logic sc_mode;
    logic ids_rise;
    logic ods_rise;
    logic ods_low;
    logic port_acc;
    logic busy;

    assign ids_act = ctrl_q[`PIO_CTL_IDS_ACT];
    assign ods_act = ctrl_q[`PIO_CTL_ODS_ACT];
    assign sc_mode = ctrl_q[`PIO_CTL_SC];
    assign busy = (state_q != pio_pkg::PIO_IDLE);
    // Port accesses wait while a transfer runs; this keeps the bus honest
    // even if software breaks the spacing it was told to keep.
    assign port_acc = port_hit(adr_i);
    assign req = cyc_i && stb_i && !ack_q && !(port_acc && busy);
    assign wr_ok = req && we_i;
    assign rd_ok = req && !we_i;

    // Three-stage synchronisers; a change counts when stages 2 and 3 agree
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ids_sync_q <= 3'h7;
            ids_lvl_q <= 1'b1;
        end else begin
            ids_sync_q <= {ids_sync_q[1:0], input_data_strobe_n_i};
            if (ids_sync_q[1] == ids_sync_q[2]) begin
                ids_lvl_q <= ids_sync_q[2];
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ods_sync_q <= 3'h7;
            ods_lvl_q <= 1'b1;
        end else begin
            ods_sync_q <= {ods_sync_q[1:0], output_data_strobe_n_i};
            if (ods_sync_q[1] == ods_sync_q[2]) begin
                ods_lvl_q <= ods_sync_q[2];
            end
        end
    end

    // Bus pipeline runs in step with the strobe stages, so stage 3 of the
    // data belongs to stage 3 of the strobe. The writer may drop its word
    // right after the rise, so the last word seen low is held.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pdb_s1_q <= 16'h0000;
            pdb_s2_q <= 16'h0000;
            pdb_s3_q <= 16'h0000;
            pdb_hold_q <= 16'h0000;
        end else begin
            pdb_s1_q <= parallel_data_bus_i;
            pdb_s2_q <= pdb_s1_q;
            pdb_s3_q <= pdb_s2_q;
            if (!ids_sync_q[2]) begin
                pdb_hold_q <= pdb_s3_q;
            end
        end
    end

    // Passive edges only count while the pin is an input
    assign ids_rise = !ids_act && !ids_lvl_q && (ids_sync_q[1] == ids_sync_q[2])
        && ids_sync_q[2];
    assign ods_rise = !ods_act && !ods_lvl_q && (ods_sync_q[1] == ods_sync_q[2])
        && ods_sync_q[2];
    assign ods_low = !ods_act && !ods_lvl_q;

    // Control register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_q <= `PIO_CTL_RESET;
        end else begin
            if (wr_ok && adr_i == `PIO_ADR_CTRL) begin
                if (sel_i[0]) begin
                    ctrl_q[7:5] <= dat_i[7:5];
                end
                if (sel_i[1]) begin
                    ctrl_q[14:8] <= dat_i[14:8];
                end
            end
            // Set wins over clear
            if (ids_rise) begin
                ctrl_q[`PIO_CTL_ST_IDS] <= 1'b1;
            end else if (rd_ok && port_acc) begin
                ctrl_q[`PIO_CTL_ST_IDS] <= 1'b0;
            end
            if (ods_rise) begin
                ctrl_q[`PIO_CTL_ST_ODS] <= 1'b1;
            end else if (wr_ok && port_acc) begin
                ctrl_q[`PIO_CTL_ST_ODS] <= 1'b0;
            end
        end
    end

    // Masked requests from passive strobe rises
    assign irq_o = (ctrl_q[`PIO_CTL_ST_IDS] && ctrl_q[`PIO_CTL_MSK_IDS])
        || (ctrl_q[`PIO_CTL_ST_ODS] && ctrl_q[`PIO_CTL_MSK_ODS]);

    // Transaction sequencer
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= pio_pkg::PIO_IDLE;
            cnt_q <= 5'h00;
            ids_on_q <= 1'b0;
            ods_on_q <= 1'b0;
        end else begin
            case (state_q)
                pio_pkg::PIO_IDLE: begin
                    // Passive mode accesses move flags, writes load out_q, no transfer
                    if (rd_ok && port_acc && ids_act) begin
                        state_q <= pio_pkg::PIO_READ;
                        cnt_q <= strobe_cycles(ctrl_q[14:13]);
                        ids_on_q <= 1'b1;
                    end else if (wr_ok && port_acc && ods_act) begin
                        state_q <= pio_pkg::PIO_WRITE;
                        cnt_q <= strobe_cycles(ctrl_q[14:13]);
                        ods_on_q <= 1'b1;
                    end
                end
                pio_pkg::PIO_READ, pio_pkg::PIO_WRITE: begin
                    if (cnt_q == 5'h01) begin
                        state_q <= pio_pkg::PIO_IDLE;
                        ids_on_q <= 1'b0;
                        ods_on_q <= 1'b0;
                    end
                    cnt_q <= cnt_q - 5'h01;
                end
                default: begin
                    state_q <= pio_pkg::PIO_IDLE;
                    ids_on_q <= 1'b0;
                    ods_on_q <= 1'b0;
                end
            endcase
        end
    end

    // Port select follows the last program port access
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sel_q <= 1'b0;
        end else if (req && port_acc) begin
            sel_q <= (adr_i == `PIO_ADR_PORT1);
        end
    end

    // Output register; writes leave the input register alone
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            out_q <= 16'h0000;
        end else if (wr_ok && port_acc) begin
            if (sel_i[0]) begin
                out_q[7:0] <= dat_i[7:0];
            end
            if (sel_i[1]) begin
                out_q[15:8] <= dat_i[15:8];
            end
        end
    end

    // Input register, shadow and acknowledge
    logic act_done;
    assign act_done = (state_q == pio_pkg::PIO_READ) && (cnt_q == 5'h01);
    logic isr_wr;
    assign isr_wr = wr_ok && (adr_i == `PIO_ADR_ISR) && sel_i[0];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            in_q <= 16'h0000;
            shadow_q <= 16'h0000;
            shadow_vld_q <= 1'b0;
            interrupt_acknowledge_q <= 1'b0;
        end else begin
            // Active sample on the last strobe-low cycle, one flop behind
            if (act_done) begin
                in_q <= pdb_s1_q;
            end else if (ids_rise) begin
                in_q <= pdb_hold_q;
            end
            if (isr_wr && dat_i[`PIO_ISR_ENTER]) begin
                interrupt_acknowledge_q <= 1'b1;
                shadow_q <= in_q;
                shadow_vld_q <= ids_act;
            end else if (isr_wr && dat_i[`PIO_ISR_EXIT]) begin
                interrupt_acknowledge_q <= 1'b0;
                shadow_vld_q <= 1'b0;
                if (shadow_vld_q && ids_act) begin
                    in_q <= shadow_q;
                end
            end
        end
    end

    // Bus outputs from flops; drivers off unless presenting data
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bus_q <= '0;
        end else begin
            bus_q.data <= out_q;
            if ((state_q == pio_pkg::PIO_WRITE) || ods_low) begin
                bus_q.oe <= sc_mode ? `PIO_LO_MASK : 16'hFFFF;
            end else begin
                bus_q.oe <= 16'h0000;
            end
        end
    end

    assign parallel_data_bus_o = bus_q.data;
    assign parallel_data_bus_oe_o = bus_q.oe;
    assign input_data_strobe_n_o = !ids_on_q;
    assign input_data_strobe_n_oe_o = ids_act;
    assign output_data_strobe_n_o = !ods_on_q;
    assign output_data_strobe_n_oe_o = ods_act;
    assign port_select_o = sel_q;
    assign interrupt_acknowledge_o = interrupt_acknowledge_q;

    // Wishbone answer, one cycle after a taken request
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            rdat_q <= 32'h0000_0000;
        end else begin
            ack_q <= req;
            rdat_q <= 32'h0000_0000;
            if (rd_ok) begin
                if (port_acc) begin
                    rdat_q <= {16'h0000, in_q};
                end else if (adr_i == `PIO_ADR_CTRL) begin
                    rdat_q <= {16'h0000, ctrl_q[`PIO_CTL_ST_IDS] & 1'b0,
                        ctrl_q[14:0]};
                end else if (adr_i == `PIO_ADR_ISR) begin
                    rdat_q <= {30'h0000_0000, shadow_vld_q, interrupt_acknowledge_q};
                end
            end
        end
    end

    assign ack_o = ack_q;
    assign dat_o = rdat_q;
endmodule : pio_port
`default_nettype wire

// ---- verilog/pio_regs.svh ----
// Register offsets, field positions, reset values and timing counts of the
// parallel I/O port. Included by the port module.
`ifndef PIO_REGS_SVH
`define PIO_REGS_SVH

// Wishbone word offsets (byte addresses)
`define PIO_ADR_PORT0 4'h0
`define PIO_ADR_PORT1 4'h4
`define PIO_ADR_CTRL 4'h8
`define PIO_ADR_ISR 4'hC

// Control register fields
`define PIO_CTL_IBF 15
`define PIO_CTL_STRB_HI 14
`define PIO_CTL_STRB_LO 13
`define PIO_CTL_ODS_ACT 12
`define PIO_CTL_IDS_ACT 11
`define PIO_CTL_SC 10
`define PIO_CTL_MSK_IDS 7
`define PIO_CTL_MSK_ODS 6
`define PIO_CTL_ST_IDS 2
`define PIO_CTL_ST_ODS 1
`define PIO_CTL_WMASK 16'h7FE0
`define PIO_CTL_RESET 16'h0008
`define PIO_CTL_BIT3 3

// Interrupt sequencing register fields
`define PIO_ISR_ENTER 0
`define PIO_ISR_EXIT 1

// Strobe unit T: two input clock periods
`define PIO_T_CYCLES 3'h2
`define PIO_LO_MASK 16'h00FF

`endif

// ---- verilog/pio_pkg.sv ----
// Types shared by the parallel I/O port.
// Assumes the constants header is on the include path.
package pio_pkg;
    typedef enum logic [2:0] {
        PIO_IDLE = 3'b001,
        PIO_READ = 3'b010,
        PIO_WRITE = 3'b100
    } pio_state_t;

    typedef struct packed {
        logic [15:0] data;
        logic [15:0] oe;
    } pio_bus_t;
endpackage : pio_pkg

// ---- tb/pio_port_sva.sv ----
// Assertion checker for the parallel I/O port.
// Sees only port pins; tracks control writes as the bus requests them, before the ack.
`timescale 1ns/1ns
`default_nettype none
module pio_port_chk (
    // Clock, reset and bus
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [3:0] adr_i,
    input wire logic [31:0] dat_i,
    input wire logic ack_o,
    // Pins
    input wire logic [15:0] parallel_data_bus_oe_o,
    input wire logic input_data_strobe_n_o,
    input wire logic input_data_strobe_n_oe_o,
    input wire logic output_data_strobe_n_i,
    input wire logic output_data_strobe_n_o,
    input wire logic output_data_strobe_n_oe_o,
    input wire logic port_select_o,
    input wire logic interrupt_acknowledge_o,
    input wire logic irq_o
);
    logic [15:0] c_q;
    logic [3:0] n_q;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    always_ff @(posedge clk_i) begin
        if (rst_i) c_q <= 16'h0008;
        else if (cyc_i && stb_i && !ack_o && we_i && adr_i == 4'h8)
            c_q <= (c_q & 16'h801F) | (dat_i[15:0] & 16'h7FE0);
    end
    // Low cycles of the driven input strobe
    always_ff @(posedge clk_i) begin
        if (rst_i || input_data_strobe_n_o) n_q <= 4'h0;
        else n_q <= n_q + 4'h1;
    end
    a_sel_port: assert property (
        ack_o && adr_i[3] == 1'b0 && adr_i[1:0] == 2'h0
        |-> port_select_o == adr_i[2]) else $error("select wrong");
    a_wr_data_on: assert property (
        $fell(output_data_strobe_n_o) && output_data_strobe_n_oe_o
        |=> parallel_data_bus_oe_o != 16'h0000) else $error("no data");
    a_strobe_width: assert property (
        $rose(input_data_strobe_n_o)
        |-> n_q == {1'b0, c_q[14:13], 1'b0} + 4'h2) else $error("width");
    a_ids_dir: assert property (
        input_data_strobe_n_oe_o == c_q[11]) else $error("ids dir");
    a_ods_dir: assert property (
        output_data_strobe_n_oe_o == c_q[12]) else $error("ods dir");
    a_sc_upper_in: assert property (
        c_q[10] |-> parallel_data_bus_oe_o[15:8] == 8'h00)
        else $error("upper byte driven");
    a_pass_rd_drive: assert property (
        $fell(output_data_strobe_n_i) && !output_data_strobe_n_oe_o
        |-> ##[1:6] parallel_data_bus_oe_o[7:0] == 8'hFF)
        else $error("passive read not driven");
    a_rd_irq: assert property (
        $rose(output_data_strobe_n_i) && !output_data_strobe_n_oe_o && c_q[6]
        |-> ##[1:6] irq_o) else $error("no read request");
    a_interrupt_acknowledge_seq: assert property (
        ack_o && we_i && adr_i == 4'hC && (dat_i[0] ^ dat_i[1])
        |=> interrupt_acknowledge_o == $past(dat_i[0])) else $error("interrupt_acknowledge");
    c_act_read: cover property ($rose(input_data_strobe_n_o));
    c_pass_irq: cover property ($rose(irq_o));
    c_interrupt_acknowledge_done: cover property ($fell(interrupt_acknowledge_o));
endmodule : pio_port_chk
bind pio_port pio_port_chk u_chk (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i,
    .adr_i, .dat_i,
    .ack_o, .parallel_data_bus_oe_o, .input_data_strobe_n_o,
    .input_data_strobe_n_oe_o, .output_data_strobe_n_i,
    .output_data_strobe_n_o, .output_data_strobe_n_oe_o, .port_select_o,
    .interrupt_acknowledge_o, .irq_o);
`default_nettype wire

// ---- tb/pio_peer.sv ----
// Far-side peripheral: answers active strobes, makes passive ones.
// Assumes the port's split pins; resolves every pin level here.
`timescale 1ns/1ns
`default_nettype none
module pio_peer (
    // Pins as the port drives them
    input wire logic clk_i,
    input wire logic [15:0] dbo_i,
    input wire logic [15:0] doe_i,
    input wire logic iso_i,
    input wire logic isoe_i,
    input wire logic oso_i,
    input wire logic osoe_i,
    input wire logic sel_i,
    // Resolved levels
    output logic [15:0] db_o,
    output logic ids_o,
    output logic ods_o
);
    logic [15:0] drv = 16'h0000, last = 16'h0000, got = 16'h0000, w;
    logic en = 1'b0, pis = 1'b1, pos = 1'b1, act, act_q = 1'b0;
    logic [3:0] n = 4'h0;
    assign act = isoe_i && !iso_i;
    assign ids_o = isoe_i ? iso_i : pis;
    assign ods_o = osoe_i ? oso_i : pos;
    assign w = act ? (sel_i ? 16'hC396 : 16'h5A3C) ^ {12'h000, n} : drv;
    // Undriven bits toggle so a stale word never looks valid
    assign db_o = (doe_i & dbo_i) | (~doe_i & ((act | en) ? w : ~last));
    always @(posedge clk_i) begin
        last <= db_o;
        act_q <= act;
        if (act_q && !act) n <= n + 4'h1;
        if (osoe_i && !oso_i) got <= db_o;
    end
    task automatic pwrite(input logic [15:0] d);
        @(posedge clk_i);
        drv <= d;
        en <= 1'b1;
        pis <= 1'b0;
        repeat (8) @(posedge clk_i);
        pis <= 1'b1;
        @(posedge clk_i);
        en <= 1'b0;
    endtask : pwrite
    task automatic pread(output logic [15:0] d);
        pos <= 1'b0;
        repeat (8) @(posedge clk_i);
        @(negedge clk_i);
        d = db_o;
        @(posedge clk_i);
        pos <= 1'b1;
    endtask : pread
endmodule : pio_peer
`default_nettype wire

// ---- tb/tb_parallel_io_port.sv ----
// Self-checking bench of the parallel I/O port.
// Assumes pio_port, pio_peer and the bound checker are compiled.
`timescale 1ns/1ns
`default_nettype none
module tb_parallel_io_port;
    logic clk_i, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [3:0] adr = 4'h0;
    logic [31:0] dw = 32'h0000_0000, dr;
    logic ack, sel, interrupt_acknowledge, irq, is_o, is_oe, os_o, os_oe, is_i, os_i;
    logic [15:0] db_i, db_o, db_oe, held = 16'h0000, q, v;
    int mismatches = 0, comparisons = 0, k = 0;
    pio_port i_pio_port (.clk_i, .rst_i, .cyc_i(cyc), .stb_i(stb),
        .we_i(we), .adr_i(adr), .sel_i(4'h3), .dat_i(dw), .dat_o(dr),
        .ack_o(ack), .parallel_data_bus_i(db_i), .parallel_data_bus_o(db_o),
        .parallel_data_bus_oe_o(db_oe), .input_data_strobe_n_i(is_i),
        .input_data_strobe_n_o(is_o), .input_data_strobe_n_oe_o(is_oe),
        .output_data_strobe_n_i(os_i), .output_data_strobe_n_o(os_o),
        .output_data_strobe_n_oe_o(os_oe), .port_select_o(sel),
        .interrupt_acknowledge_o(interrupt_acknowledge), .irq_o(irq));
    pio_peer peer (.clk_i, .dbo_i(db_o), .doe_i(db_oe), .iso_i(is_o),
        .isoe_i(is_oe), .oso_i(os_o), .osoe_i(os_oe), .sel_i(sel),
        .db_o(db_i), .ids_o(is_i), .ods_o(os_i));
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : tally_and_finish
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        comparisons++;
        if (g !== e) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk
    // Entered just after a rising edge; request held until ack is sampled
    task automatic wb(input logic w, input logic [3:0] a, input logic [15:0] d);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dw <= {16'h0000, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 40);
        if (ack !== 1'b1) begin
            mismatches++;
            tally_and_finish;
        end
        q = dr[15:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_i);
    endtask : wb
    // Active read: returns the word the previous transfer loaded
    task automatic rd(input logic p);
        wb(1'b0, {1'b0, p, 2'b00}, 16'h0000);
        chk(q, held);
        held = (p ? 16'hC396 : 16'h5A3C) ^ 16'(k);
        k++;
    endtask : rd
    task automatic t_active;
        wb(1'b0, 4'h8, 16'h0000);
        chk(q, 16'h0008);
        wb(1'b0, 4'h2, 16'h0000);
        chk(q, 16'h0000);
        wb(1'b1, 4'h8, 16'h1800);
        wb(1'b0, 4'h0, 16'h0000);
        held = 16'h5A3C;
        k = 1;
        rd(1'b1);
        rd(1'b0);
        rd(1'b1);
        wb(1'b1, 4'h0, 16'h0F0F);
        repeat (6) @(posedge clk_i);
        chk(peer.got, 16'h0F0F);
        rd(1'b0);
        for (int c = 1; c < 4; c++) begin
            wb(1'b1, 4'h8, 16'h1800 | 16'(c << 13));
            rd(1'b0);
            repeat (10) @(posedge clk_i);
        end
    endtask : t_active
    task automatic t_shadow;
        logic [15:0] s;
        s = held;
        wb(1'b1, 4'hC, 16'h0001);
        chk({15'h0000, interrupt_acknowledge}, 16'h0001);
        rd(1'b1);
        repeat (12) @(posedge clk_i);
        wb(1'b1, 4'hC, 16'h0002);
        chk({15'h0000, interrupt_acknowledge}, 16'h0000);
        held = s;
        rd(1'b0);
    endtask : t_shadow
    task automatic t_passive;
        repeat (10) @(posedge clk_i);
        wb(1'b1, 4'h8, 16'h00C0);
        peer.pwrite(16'h1234);
        repeat (6) @(negedge clk_i);
        chk({15'h0000, irq}, 16'h0001);
        @(posedge clk_i);
        wb(1'b0, 4'h0, 16'h0000);
        chk(q, 16'h1234);
        wb(1'b0, 4'h8, 16'h0000);
        chk(q, 16'h00C8);
        wb(1'b1, 4'h4, 16'hBEEF);
        peer.pread(v);
        chk(v, 16'hBEEF);
        repeat (6) @(posedge clk_i);
        wb(1'b0, 4'h8, 16'h0000);
        chk(q, 16'h00CA);
        wb(1'b1, 4'h8, 16'h0400);
        wb(1'b1, 4'h0, 16'hABCD);
        wb(1'b0, 4'h8, 16'h0000);
        chk(q, 16'h0408);
        peer.pread(v);
        chk({8'h00, v[7:0]}, 16'h00CD);
    endtask : t_passive
    initial begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        t_active;
        t_shadow;
        t_passive;
        tally_and_finish;
    end
endmodule : tb_parallel_io_port
`default_nettype wire
